// File: core/hbf_delay_timer.sv
// Delay timer that restarts whenever its condition drops
`timescale 1ns/1ps
module hbf_delay_timer #(
  parameter int COUNT = 1
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // Condition and expiry
  input wire logic i_run,
  output logic o_done
);
  localparam int CW = $clog2(COUNT + 1);
  logic [CW-1:0] count;

  if (COUNT < 1) begin : g_bad_count
    $error("hbf_delay_timer: COUNT must be at least 1");
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b || !i_run) begin
      count <= '0;
    end else if (count != CW'(COUNT)) begin
      count <= count + CW'(1);
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b || !i_run) begin
      o_done <= 1'b0;
    end else begin
      o_done <= (count == CW'(COUNT - 1)) || (count == CW'(COUNT));
    end
  end
endmodule // hbf_delay_timer

// File: core/hbf_fault_status.sv
// Fault supervision, latched status and serial status return
`timescale 1ns/1ps
module hbf_fault_status
  import hbf_pkg::*;
#(
  parameter int OC_DELAY = OC_DELAY_CYC,
  parameter int UL_DELAY = UL_DELAY_CYC,
  parameter int SRR_HOLD = SRR_HOLD_CYC
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // Serial link
  input wire logic i_chip_select_low,
  input wire logic i_sclk,
  input wire logic i_sdi,
  output logic o_sdo,
  output logic o_sdo_oe_b,
  // Enable pin and supply comparators
  input wire logic i_enable,
  input wire logic i_driver_supply_uv,
  input wire logic i_driver_supply_ov,
  input wire logic i_logic_supply_uv,
  // Fault comparators
  input wire logic [2*CHANNELS-1:0] i_overcurrent,
  input wire logic [2*CHANNELS-1:0] i_underload,
  input wire logic [CHANNELS-1:0] i_temp_warning,
  input wire logic [CHANNELS-1:0] i_temp_shutdown,
  // Bridge drivers
  output logic [CHANNELS-1:0] o_high_side_on,
  output logic [CHANNELS-1:0] o_low_side_on,
  // Status
  output logic o_supply_fail_flag,
  output logic o_overcurrent_flag,
  output logic o_underload_flag,
  output logic o_thermal_warning_flag,
  output logic o_thermal_shutdown_flag,
  output logic [2*CHANNELS-1:0] o_channel_fault_code
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  localparam int HOLD_W = $clog2(SRR_HOLD + 1);
  localparam int SYNC_W = 7 + 6 * CHANNELS;

  if (SRR_HOLD < 1 || OC_DELAY < 1 || UL_DELAY < 1) begin : g_bad_param
    $error("hbf_fault_status: delay counts must be at least 1");
  end
  if (CHANNELS != 2 * GROUP_SIZE) begin : g_bad_groups
    $error("hbf_fault_status: channels must form two groups");
  end

  function automatic logic [CHANNELS-1:0] group_mask(input logic grp);
    group_mask = grp ? {{GROUP_SIZE{1'b1}}, {GROUP_SIZE{1'b0}}} : {{GROUP_SIZE{1'b0}}, {GROUP_SIZE{1'b1}}};
  endfunction

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  hbf_sync_if #(.WIDTH(SYNC_W)) pins_if ();

  logic csb_s;
  logic sclk_s;
  logic sdi_s;
  logic en_s;
  logic vs_uv_s;
  logic vs_ov_s;
  logic vcc_uv_s;
  logic [2*CHANNELS-1:0] oc_s;
  logic [2*CHANNELS-1:0] ul_s;
  logic [CHANNELS-1:0] tw_s;
  logic [CHANNELS-1:0] tsd_s;

  assign pins_if.raw = {i_temp_shutdown, i_temp_warning, i_underload, i_overcurrent, i_logic_supply_uv,
                        i_driver_supply_ov, i_driver_supply_uv, i_enable, i_sdi, i_sclk, i_chip_select_low};

  hbf_pin_sync #(
    .WIDTH(SYNC_W),
    .RESET_LEVEL(SYNC_W'(1))
  ) u_sync (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .sig(pins_if)
  );

  assign {tsd_s, tw_s, ul_s, oc_s, vcc_uv_s, vs_ov_s, vs_uv_s, en_s, sdi_s, sclk_s, csb_s} = pins_if.level;

  // ----------------------------------------------------------------
  // Link edges and frame state
  // ----------------------------------------------------------------
  hbf_link_type link_state;
  logic csb_d;
  logic sclk_d;
  logic frame_start;
  logic frame_end;
  logic sclk_rise;
  logic sclk_fall;
  logic [15:0] rx_word;
  logic [15:0] tx_word;
  logic [4:0] bit_cnt;
  logic frame_ok;
  logic srr_go;
  logic [HOLD_W-1:0] hold_cnt;
  logic [CHANNELS-1:0] clr_mask;
  logic [CHANNELS-1:0] rx_mask;
  logic clear_all;

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      csb_d <= 1'b1;
      sclk_d <= 1'b0;
    end else begin
      csb_d <= csb_s;
      sclk_d <= sclk_s;
    end
  end

  assign frame_start = csb_d & ~csb_s & ~vcc_uv_s;
  assign frame_end = ~csb_d & csb_s;
  assign sclk_rise = ~sclk_d & sclk_s & ~csb_s;
  assign sclk_fall = sclk_d & ~sclk_s & ~csb_s;
  assign frame_ok = frame_end & (link_state != LINK_IDLE) & (bit_cnt == 5'(FRAME_BITS));
  assign srr_go = frame_ok & rx_word[CMD_SRR_BIT] & (hold_cnt == '0);
  assign rx_mask = group_mask(rx_word[CMD_GRP_BIT]);
  assign clr_mask = srr_go ? rx_mask : '0;
  assign clear_all = vcc_uv_s | ~en_s;

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b || vcc_uv_s) begin
      link_state <= LINK_IDLE;
    end else begin
      unique case (link_state)
        LINK_IDLE: begin
          if (frame_start) begin
            link_state <= LINK_PRE;
          end
        end
        LINK_PRE: begin
          if (frame_end) begin
            link_state <= LINK_IDLE;
          end else if (sclk_rise) begin
            link_state <= LINK_SHIFT;
          end
        end
        LINK_SHIFT: begin
          if (frame_end) begin
            link_state <= LINK_IDLE;
          end
        end
        default: begin
          link_state <= LINK_IDLE;
        end
      endcase
    end
  end

  // Receive shift register and bit count
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b || vcc_uv_s) begin
      rx_word <= WORD_RESET;
      bit_cnt <= '0;
    end else if (frame_start) begin
      bit_cnt <= '0;
    end else if (sclk_fall && link_state != LINK_IDLE) begin
      rx_word <= {rx_word[14:0], sdi_s};
      if (bit_cnt != 5'h1F) begin
        bit_cnt <= bit_cnt + 5'h1;
      end
    end
  end

  // STATUS_RESET_REQUEST hold-off timer
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      hold_cnt <= '0;
    end else if (srr_go) begin
      hold_cnt <= HOLD_W'(SRR_HOLD);
    end else if (hold_cnt != '0) begin
      hold_cnt <= hold_cnt - HOLD_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // Command register
  // ----------------------------------------------------------------
  logic cmd_grp;
  logic cmd_overvoltage_lockout_enable;
  logic cmd_underload_shutdown_enable;
  logic [CHANNELS-1:0] ch_en;
  logic [CHANNELS-1:0] ch_cfg;

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b || vcc_uv_s) begin
      cmd_grp <= 1'b0;
      cmd_overvoltage_lockout_enable <= 1'b0;
      cmd_underload_shutdown_enable <= 1'b0;
      ch_en <= '0;
      ch_cfg <= '0;
    end else if (frame_ok) begin
      cmd_grp <= rx_word[CMD_GRP_BIT];
      cmd_overvoltage_lockout_enable <= rx_word[CMD_OVERVOLTAGE_LOCKOUT_ENABLE_BIT];
      cmd_underload_shutdown_enable <= rx_word[CMD_UNDERLOAD_SHUTDOWN_ENABLE_BIT];
      for (int ch = 0; ch < CHANNELS; ch++) begin
        if (rx_mask[ch]) begin
          ch_en[ch] <= rx_word[CMD_CH_LSB + 2 * (ch % GROUP_SIZE) + 1];
          ch_cfg[ch] <= rx_word[CMD_CH_LSB + 2 * (ch % GROUP_SIZE)];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Fault timers
  // ----------------------------------------------------------------
  logic [CHANNELS-1:0] ch_off;
  logic [CHANNELS-1:0] oc_done;
  logic [CHANNELS-1:0] ul_ch;
  logic [CHANNELS-1:0] ul_trip;
  logic ul_done;

  for (genvar g = 0; g < CHANNELS; g++) begin : g_oc
    assign ul_ch[g] = ul_s[2*g] | ul_s[2*g+1];
    hbf_delay_timer #(.COUNT(OC_DELAY)) u_oc_timer (
      .i_mclk(i_mclk),
      .i_rst_b(i_rst_b),
      .i_run((oc_s[2*g] | oc_s[2*g+1]) & ~ch_off[g] & ~clear_all),
      .o_done(oc_done[g])
    );
  end

  // Shared timer keeps running while any channel is underloaded
  hbf_delay_timer #(.COUNT(UL_DELAY)) u_ul_timer (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_run((|ul_ch) & ~clear_all),
    .o_done(ul_done)
  );

  assign ul_trip = ul_ch & {CHANNELS{ul_done}};

  // ----------------------------------------------------------------
  // Latched per-channel status
  // ----------------------------------------------------------------
  logic [CHANNELS-1:0] tsd_latch;

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b || clear_all) begin
      o_channel_fault_code <= '0;
    end else begin
      for (int ch = 0; ch < CHANNELS; ch++) begin
        if (clr_mask[ch]) begin
          o_channel_fault_code[2*ch +: 2] <= CODE_NONE;
        end
        if (oc_done[ch]) begin
          o_channel_fault_code[2*ch +: 2] <= CODE_OC;
        end else if (ul_trip[ch] && o_channel_fault_code[2*ch +: 2] == CODE_NONE) begin
          o_channel_fault_code[2*ch +: 2] <= CODE_UL;
        end
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b || clear_all) begin
      ch_off <= '0;
    end else begin
      ch_off <= (ch_off & ~clr_mask) | oc_done | tsd_s | (ul_trip & {CHANNELS{cmd_underload_shutdown_enable}});
    end
  end

  // Still-hot sensor re-sets the latch over the clear
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b || clear_all) begin
      tsd_latch <= '0;
    end else begin
      tsd_latch <= (tsd_latch & ~clr_mask) | tsd_s;
    end
  end

  // ----------------------------------------------------------------
  // Global flags
  // ----------------------------------------------------------------
  logic any_oc;
  logic any_ul;

  always_comb begin
    any_oc = 1'b0;
    any_ul = 1'b0;
    for (int ch = 0; ch < CHANNELS; ch++) begin
      any_oc = any_oc | (o_channel_fault_code[2*ch +: 2] == CODE_OC);
      any_ul = any_ul | (o_channel_fault_code[2*ch +: 2] == CODE_UL);
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b || clear_all) begin
      o_supply_fail_flag <= 1'b0;
      o_overcurrent_flag <= 1'b0;
      o_underload_flag <= 1'b0;
      o_thermal_warning_flag <= 1'b0;
      o_thermal_shutdown_flag <= 1'b0;
    end else begin
      o_supply_fail_flag <= vs_uv_s | vs_ov_s;
      o_overcurrent_flag <= any_oc;
      o_underload_flag <= any_ul;
      o_thermal_warning_flag <= (|tw_s) | (|tsd_s);
      o_thermal_shutdown_flag <= |tsd_latch;
    end
  end

  // ----------------------------------------------------------------
  // Bridge drivers
  // ----------------------------------------------------------------
  logic lockout;
  logic [CHANNELS-1:0] drive;

  assign lockout = vs_uv_s | (vs_ov_s & cmd_overvoltage_lockout_enable) | vcc_uv_s | ~en_s;
  assign drive = ch_en & ~ch_off & {CHANNELS{~lockout}};

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      o_high_side_on <= '0;
      o_low_side_on <= '0;
    end else begin
      o_high_side_on <= drive & ch_cfg;
      o_low_side_on <= drive & ~ch_cfg;
    end
  end

  // ----------------------------------------------------------------
  // Status return
  // ----------------------------------------------------------------
  logic [15:0] sta_word;

  always_comb begin
    sta_word = WORD_RESET;
    sta_word[STA_TW_BIT] = o_thermal_warning_flag;
    sta_word[STA_ULD_BIT] = o_underload_flag;
    sta_word[STA_PSF_BIT] = o_supply_fail_flag;
    sta_word[STA_OCS_BIT] = o_overcurrent_flag;
    for (int i = 0; i < GROUP_SIZE; i++) begin
      sta_word[STA_CODE_LSB + 2*i +: 2] = o_channel_fault_code[2*(i + (cmd_grp ? GROUP_SIZE : 0)) +: 2];
    end
  end

  // Snapshot taken at frame start shifts left on each clock rise until the frame ends
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b || vcc_uv_s) begin
      tx_word <= WORD_RESET;
    end else if (frame_start) begin
      tx_word <= sta_word;
    end else if (sclk_rise && link_state != LINK_IDLE) begin
      tx_word <= {tx_word[14:0], 1'b0};
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b || vcc_uv_s) begin
      o_sdo <= 1'b0;
    end else if (sclk_rise && link_state != LINK_IDLE) begin
      o_sdo <= tx_word[15];
    end else if (link_state == LINK_PRE || frame_start) begin
      o_sdo <= o_thermal_shutdown_flag | sdi_s;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b || vcc_uv_s) begin
      o_sdo_oe_b <= 1'b1;
    end else begin
      o_sdo_oe_b <= ~(frame_start | ((link_state != LINK_IDLE) & ~frame_end));
    end
  end

endmodule // hbf_fault_status

// File: core/hbf_pin_sync.sv
// Three-stage synchroniser with agreement filter
`timescale 1ns/1ps
module hbf_pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_LEVEL = '0
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // Inputs and filtered levels
  hbf_sync_if.sync sig
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  if (WIDTH < 1) begin : g_bad_width
    $error("hbf_pin_sync: WIDTH must be at least 1");
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      stage1 <= RESET_LEVEL;
      stage2 <= RESET_LEVEL;
      stage3 <= RESET_LEVEL;
    end else begin
      stage1 <= sig.raw;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // Level follows only where the second and third stages agree
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      sig.level <= RESET_LEVEL;
    end else begin
      sig.level <= (stage2 & ~(stage2 ^ stage3)) | (sig.level & (stage2 ^ stage3));
    end
  end
endmodule // hbf_pin_sync

// File: core/hbf_pkg.sv
// Shared constants and types for the half-bridge fault and status logic
package hbf_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int CHANNELS = 12;
  localparam int GROUP_SIZE = 6;
  localparam int FRAME_BITS = 16;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int OC_DELAY_NS = 10000;
  localparam int OC_DELAY_CYC = (OC_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int UL_DELAY_NS = 200000;
  localparam int UL_DELAY_CYC = (UL_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SRR_HOLD_NS = 100000;
  localparam int SRR_HOLD_CYC = (SRR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Command word fields
  // ----------------------------------------------------------------
  localparam int CMD_SRR_BIT = 15;
  localparam int CMD_GRP_BIT = 14;
  localparam int CMD_CH_LSB = 2;
  localparam int CMD_UNDERLOAD_SHUTDOWN_ENABLE_BIT = 1;
  localparam int CMD_OVERVOLTAGE_LOCKOUT_ENABLE_BIT = 0;

  // ----------------------------------------------------------------
  // Status word fields
  // ----------------------------------------------------------------
  localparam int STA_TW_BIT = 15;
  localparam int STA_CODE_LSB = 3;
  localparam int STA_ULD_BIT = 2;
  localparam int STA_PSF_BIT = 1;
  localparam int STA_OCS_BIT = 0;

  // ----------------------------------------------------------------
  // Codes and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] CODE_NONE = 2'h0;
  localparam logic [1:0] CODE_OC = 2'h1;
  localparam logic [1:0] CODE_UL = 2'h2;
  localparam logic [15:0] WORD_RESET = 16'h0000;

  typedef enum logic [2:0] {
    LINK_IDLE = 3'h1,
    LINK_PRE = 3'h2,
    LINK_SHIFT = 3'h4
  } hbf_link_type;

endpackage

// File: core/hbf_sync_if.sv
// Raw and filtered levels of asynchronous inputs
`timescale 1ns/1ps
interface hbf_sync_if #(
  parameter int WIDTH = 1
);
  logic [WIDTH-1:0] raw;
  logic [WIDTH-1:0] level;
  modport source (output raw, input level);
  modport sync (input raw, output level);
endinterface

// File: tb/hbf_fault_sva.sv
// Concurrent checks on the fault and status ports
`timescale 1ns/1ps
module hbf_fault_sva
  import hbf_pkg::*;
#(
  parameter int OC_DELAY = OC_DELAY_CYC
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // Pins and comparators
  input wire logic i_chip_select_low,
  input wire logic i_sdi,
  input wire logic i_enable,
  input wire logic i_driver_supply_uv,
  input wire logic i_driver_supply_ov,
  input wire logic i_logic_supply_uv,
  input wire logic [2*CHANNELS-1:0] i_overcurrent,
  input wire logic [CHANNELS-1:0] i_temp_warning,
  input wire logic [CHANNELS-1:0] i_temp_shutdown,
  // Outputs
  input wire logic o_sdo,
  input wire logic o_sdo_oe_b,
  input wire logic [CHANNELS-1:0] o_high_side_on,
  input wire logic [CHANNELS-1:0] o_low_side_on,
  input wire logic o_supply_fail_flag,
  input wire logic o_thermal_warning_flag,
  input wire logic o_thermal_shutdown_flag,
  input wire logic [2*CHANNELS-1:0] o_channel_fault_code
);
  wire live = i_enable && !i_logic_supply_uv;
  wire off = !(|o_high_side_on) && !(|o_low_side_on);
  logic oc_on;
  int oc_run;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);
  sequence s_frame_start;
    $fell(o_sdo_oe_b) ##0 !i_sdi;
  endsequence
  always_comb begin
    oc_on = 1'b0;
    for (int c = 0; c < CHANNELS; c++) begin
      if (o_channel_fault_code[2*c+:2] == CODE_OC && (o_high_side_on[c] || o_low_side_on[c])) begin
        oc_on = 1'b1;
      end
    end
  end
  // Length of an unbroken overcurrent on channel 0 low side
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b || !(i_overcurrent[0] && live)) begin
      oc_run <= 0;
    end else if (oc_run < OC_DELAY + 8) begin
      oc_run <= oc_run + 1;
    end
  end
  chk_uv_outputs_off: assert property ((i_driver_supply_uv && live) [*8] |-> off && o_supply_fail_flag)
    else $error("undervoltage outputs");
  chk_ov_flag_set: assert property ((i_driver_supply_ov && live) [*8] |-> o_supply_fail_flag)
    else $error("overvoltage flag");
  chk_logic_uv_clear: assert property (i_logic_supply_uv [*8] |-> off && o_channel_fault_code == '0 && o_sdo_oe_b)
    else $error("logic undervoltage");
  chk_enable_clear: assert property ((!i_enable) [*8] |-> off && o_channel_fault_code == '0)
    else $error("enable low");
  chk_oc_code_set: assert property (oc_run == OC_DELAY + 8 |-> o_channel_fault_code[1:0] == CODE_OC)
    else $error("overcurrent code");
  chk_oc_drivers_off: assert property (not (oc_on [*3]))
    else $error("overcurrent driver on");
  chk_tw_follows: assert property ((|i_temp_warning && live) [*8] |-> o_thermal_warning_flag)
    else $error("warning missing");
  chk_tw_clears: assert property ((!(|i_temp_warning) && !(|i_temp_shutdown)) [*8] |-> !o_thermal_warning_flag)
    else $error("warning stuck");
  chk_tsd_latch: assert property ((|i_temp_shutdown && live) [*8] |-> o_thermal_shutdown_flag && o_thermal_warning_flag)
    else $error("shutdown flags");
  chk_preframe_tsd: assert property (s_frame_start |-> o_sdo == o_thermal_shutdown_flag)
    else $error("pre-frame bit");
  chk_so_released: assert property (i_chip_select_low [*8] |-> o_sdo_oe_b)
    else $error("serial out driven");
endmodule // hbf_fault_sva
bind hbf_fault_status hbf_fault_sva #(.OC_DELAY(OC_DELAY)) i_hbf_fault_sva (.*);

// File: tb/hbf_host_model.sv
// Host serial master model driving the status link
`timescale 1ns/1ps
module hbf_host_model (
  // Serial link
  output logic o_chip_select_low,
  output logic o_sclk,
  output logic o_sdi,
  input wire logic i_sdo,
  input wire logic i_sdo_oe_b
);
  logic [15:0] rx;
  logic pre;
  initial begin
    o_chip_select_low = 1'b1;
    o_sclk = 1'b0;
    o_sdi = 1'b0;
    rx = 16'h0000;
    pre = 1'b0;
  end
  // One frame, MSB first, clock still and data low outside it
  task automatic frame(input logic [15:0] cmd);
    o_sclk = 1'b0;
    o_sdi = 1'b0;
    #100 o_chip_select_low = 1'b0;
    #140 pre = i_sdo_oe_b ? 1'b0 : i_sdo;
    for (int b = 15; b >= 0; b--) begin
      #80 o_sclk = 1'b1;
      o_sdi = cmd[b];
      #70 rx[b] = i_sdo;
      #10 o_sclk = 1'b0;
    end
    #80 o_chip_select_low = 1'b1;
    o_sdi = 1'b0;
    #100;
  endtask
endmodule // hbf_host_model

// File: tb/test_hbf_fault_status.sv
// Self-checking bench of the fault and status logic
`timescale 1ns/1ps
module test_hbf_fault_status;
  import hbf_pkg::*;
  logic i_mclk, i_rst_b, i_chip_select_low, i_sclk, i_sdi, i_enable;
  logic i_driver_supply_uv, i_driver_supply_ov, i_logic_supply_uv;
  logic [2*CHANNELS-1:0] i_overcurrent, i_underload, o_channel_fault_code;
  logic [CHANNELS-1:0] i_temp_warning, i_temp_shutdown, o_high_side_on, o_low_side_on;
  logic o_sdo, o_sdo_oe_b, o_supply_fail_flag, o_overcurrent_flag, o_underload_flag;
  logic o_thermal_warning_flag, o_thermal_shutdown_flag;
  int n_errors, samples_checked;
  localparam logic [11:0] HS = 12'hA95;
  localparam logic [11:0] LS = 12'h56A;
  hbf_fault_status #(.OC_DELAY(5), .UL_DELAY(20), .SRR_HOLD(50)) i_hbf_fault_status (.*);
  hbf_host_model i_hbf_host_model (.o_chip_select_low(i_chip_select_low), .o_sclk(i_sclk), .o_sdi(i_sdi),
    .i_sdo(o_sdo), .i_sdo_oe_b(o_sdo_oe_b));
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge i_mclk);
  endtask
  task automatic send(input logic [15:0] w);
    i_hbf_host_model.frame(w);
    cyc(2);
  endtask
  function automatic logic [15:0] mk(input logic status_reset_request, grp, input logic [5:0] cfg, input logic underload_flag, ov);
    logic [15:0] w;
    w = {status_reset_request, grp, 12'h000, underload_flag, ov};
    for (int i = 0; i < GROUP_SIZE; i++) begin
      w[2*i+3] = 1'b1;
      w[2*i+2] = cfg[i];
    end
    return w;
  endfunction
  task automatic t_program;
    check({o_sdo_oe_b, o_high_side_on, o_low_side_on}, {1'b1, 24'h0});
    send(mk(0, 0, 6'h15, 0, 1));
    send(mk(0, 1, 6'h2A, 0, 1));
    check(i_hbf_host_model.rx, 16'h0000);
    check({o_high_side_on, o_low_side_on}, {HS, LS});
  endtask
  task automatic t_supply;
    i_driver_supply_uv = 1'b1;
    cyc(10);
    check({o_supply_fail_flag, o_high_side_on, o_low_side_on}, {1'b1, 24'h0});
    send(mk(0, 1, 6'h3F, 0, 1));
    i_driver_supply_uv = 1'b0;
    cyc(10);
    check({o_supply_fail_flag, o_high_side_on}, {1'b0, 6'h3F, HS[5:0]});
    send(mk(0, 1, 6'h2A, 0, 1));
    i_driver_supply_ov = 1'b1;
    cyc(10);
    check({o_high_side_on, o_low_side_on}, 24'h0);
    send(mk(0, 1, 6'h2A, 0, 0));
    check({o_supply_fail_flag, o_high_side_on, o_low_side_on}, {1'b1, HS, LS});
    i_driver_supply_ov = 1'b0;
    send(mk(0, 0, 6'h15, 0, 1));
  endtask
  task automatic t_overcurrent;
    i_overcurrent[7] = 1'b1;
    cyc(3);
    i_overcurrent = 24'h020020;
    cyc(20);
    i_overcurrent = '0;
    check({o_overcurrent_flag, o_channel_fault_code}, 25'h1010010);
    check({o_high_side_on, o_low_side_on}, {HS & 12'hEFB, LS & 12'hEFB});
    send(mk(1, 0, 6'h15, 0, 1));
    check(i_hbf_host_model.rx, 16'h0081);
    check(o_channel_fault_code, 24'h010000);
    send(mk(1, 1, 6'h2A, 0, 1));
    check({o_overcurrent_flag, o_channel_fault_code, o_high_side_on, o_low_side_on}, {1'b0, 24'h0, HS, LS});
  endtask
  task automatic t_underload;
    send(mk(0, 0, 6'h15, 1, 1));
    i_underload[9] = 1'b1;
    cyc(12);
    i_underload[11] = 1'b1;
    cyc(18);
    i_underload = '0;
    check({o_underload_flag, o_channel_fault_code}, 25'h1000A00);
    check(o_high_side_on | o_low_side_on, 12'hFCF);
    send(mk(1, 0, 6'h15, 0, 1));
    check({o_underload_flag, o_channel_fault_code, o_low_side_on}, {1'b0, 24'h0, LS});
  endtask
  task automatic t_thermal;
    i_temp_warning[0] = 1'b1;
    cyc(10);
    check({o_thermal_warning_flag, o_high_side_on, o_low_side_on}, {1'b1, HS, LS});
    i_temp_shutdown[1] = 1'b1;
    cyc(10);
    check({o_thermal_shutdown_flag, o_high_side_on, o_low_side_on}, {1'b1, HS, LS & 12'hFFD});
    send(mk(1, 0, 6'h15, 0, 1));
    check({i_hbf_host_model.pre, o_thermal_shutdown_flag}, 2'h3);
    i_temp_warning = '0;
    i_temp_shutdown = '0;
    cyc(10);
    check(o_thermal_warning_flag, 1'b0);
    send(mk(1, 0, 6'h15, 0, 1));
    check({o_thermal_shutdown_flag, o_high_side_on, o_low_side_on}, {1'b0, HS, LS});
  endtask
  task automatic t_enable;
    i_overcurrent[0] = 1'b1;
    cyc(20);
    i_overcurrent[0] = 1'b0;
    check(o_overcurrent_flag, 1'b1);
    i_enable = 1'b0;
    cyc(10);
    check({o_overcurrent_flag, o_channel_fault_code, o_high_side_on, o_low_side_on}, 49'h0);
    i_enable = 1'b1;
    cyc(10);
    check({o_high_side_on, o_low_side_on}, {HS, LS});
    i_logic_supply_uv = 1'b1;
    cyc(10);
    i_logic_supply_uv = 1'b0;
    cyc(10);
    check({o_high_side_on, o_low_side_on}, 24'h0);
  endtask
  initial begin
    i_rst_b = 1'b0;
    i_enable = 1'b1;
    i_driver_supply_uv = 1'b0;
    i_driver_supply_ov = 1'b0;
    i_logic_supply_uv = 1'b0;
    i_overcurrent = '0;
    i_underload = '0;
    i_temp_warning = '0;
    i_temp_shutdown = '0;
    n_errors = 0;
    samples_checked = 0;
    cyc(16);
    i_rst_b = 1'b1;
    cyc(8);
    t_program;
    t_supply;
    t_overcurrent;
    t_underload;
    t_thermal;
    t_enable;
    give_verdict;
  end
  initial begin
    #500000;
    n_errors++;
    give_verdict;
  end
endmodule // test_hbf_fault_status
